// [msp_accum.sv]
// Saturating x and y movement accumulators with clear on read.
// Assumes deltas and the clear come from logic on the same clock.
`timescale 1ns/1ns

module msp_accum
	import msp_pkg::*;
(
	// Clock and control
	input  wire logic  clk,
	input  wire logic  sys_rst,
	input  wire logic  clk_en,
	// Movement in
	input  wire logic  add_en,
	input  msp_motion_t delta,
	input  wire logic  clear,
	// Accumulated movement
	output msp_motion_t acc_q
);

	msp_motion_t acc_d;
	msp_motion_t base;

	function automatic logic signed [AXIS_W-1:0] sat_add(
		input logic signed [AXIS_W-1:0] a,
		input logic signed [AXIS_W-1:0] b);
		logic signed [AXIS_W:0] s;
		s = {a[AXIS_W-1], a} + {b[AXIS_W-1], b};
		if (s[AXIS_W] != s[AXIS_W-1])
		begin
			s[AXIS_W-1:0] = {s[AXIS_W], {(AXIS_W-1){~s[AXIS_W]}}};
		end
		return s[AXIS_W-1:0];
	endfunction

	// ==========================================================
	// Next values
	// A delta arriving with the clear is kept for the next read.
	always_comb
	begin
		base  = clear ? MOTION_ZERO : acc_q;
		acc_d = base;
		if (add_en)
		begin
			acc_d.x = sat_add(base.x, delta.x);
			acc_d.y = sat_add(base.y, delta.y);
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			acc_q <= MOTION_ZERO;
		end
		else if (clk_en)
		begin
			acc_q <= acc_d;
		end
	end

endmodule

// [msp_ctrl_model.sv]
// Controller model: drives the hibernate request and command pulses.
// Assumes the sequencer samples its inputs on the rising clock edge.
`timescale 1ns/1ns

module msp_ctrl_model
	import msp_pkg::*;
#(
	parameter int GAP = 3
)
(
	// Clock and status
	input  wire logic clk,
	input  wire logic motion_ready_q,
	// Requests
	output logic      hibernate_request_pin,
	output logic      cmd_read_track,
	output logic      cmd_soft_reset
);
	initial
	begin
		hibernate_request_pin = 1'b0;
		cmd_read_track = 1'b0;
		cmd_soft_reset = 1'b0;
	end

	// ==========================================================
	// Commands
	// Each command is a one-cycle pulse followed by a quiet gap of GAP cycles.
	task automatic pulse(input bit rd);
		@(negedge clk);
		cmd_read_track = rd;
		cmd_soft_reset = !rd;
		@(negedge clk);
		cmd_read_track = 1'b0;
		cmd_soft_reset = 1'b0;
		repeat (GAP) @(negedge clk);
	endtask

	// ==========================================================
	// Hibernate request
	task automatic set_hib(input bit v);
		@(negedge clk);
		hibernate_request_pin = v;
	endtask

	// ==========================================================
	// Readiness
	// Waits at most lim cycles for motion ready and reports how many passed.
	task automatic wait_ready(input int lim, output int n);
		for (n = 0; n < lim && motion_ready_q !== 1'b1; n++)
			@(negedge clk);
	endtask
endmodule

// [msp_pkg.sv]
// Shared types and constants of the motion sensor power-mode sequencer.
// Assumes a single 100 MHz clock and a synchronous active-high reset.

package msp_pkg;

	// ==========================================================
	// Clock and timing
	localparam longint unsigned CLK_HZ       = 100_000_000;
	localparam longint unsigned RESET_MS     = 100;
	localparam longint unsigned WAKE_MS      = 20;
	localparam longint unsigned NAP_S        = 4;
	localparam longint unsigned SLEEP_S      = 30;
	// Millisecond times round down to whole cycles.
	localparam logic [31:0] RESET_CYC = 32'(RESET_MS * CLK_HZ / 1000);
	localparam logic [31:0] WAKE_CYC  = 32'(WAKE_MS * CLK_HZ / 1000);
	localparam logic [31:0] NAP_CYC   = 32'(NAP_S * CLK_HZ);
	localparam logic [31:0] SLEEP_CYC = 32'(SLEEP_S * CLK_HZ);

	// ==========================================================
	// Widths and reset values
	localparam int          AXIS_W     = 16;
	localparam logic [31:0] TIMER_RST  = 32'h0000_0000;
	localparam logic [2:0]  SYNC_RST   = 3'h0;

	// ==========================================================
	// Types
	typedef enum logic [2:0] {
		MSP_RESET,
		MSP_TRACK,
		MSP_NAP,
		MSP_SLEEP,
		MSP_HIBER,
		MSP_WAKE
	} msp_mode_t;

	typedef struct packed {
		logic signed [AXIS_W-1:0] x;
		logic signed [AXIS_W-1:0] y;
	} msp_motion_t;

	localparam msp_motion_t MOTION_ZERO = '0;

endpackage

// [msp_sync.sv]
// Three-stage synchroniser with agreement filter for one pin level.
// Assumes the pin is asynchronous to clk.
`timescale 1ns/1ns

module msp_sync
	import msp_pkg::*;
(
	// Clock and control
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic clk_en,
	// Pin and clean level
	input  wire logic pin_in,
	output logic      level_q
);

	logic [2:0] stage_q;
	logic [2:0] stage_d;
	logic       level_d;

	// ==========================================================
	// Next values
	// The level moves only when the second and third stages agree.
	always_comb
	begin
		stage_d = {stage_q[1:0], pin_in};
		level_d = level_q;
		if (stage_q[1] == stage_q[2])
		begin
			level_d = stage_q[2];
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			stage_q <= SYNC_RST;
			level_q <= 1'b0;
		end
		else if (clk_en)
		begin
			stage_q <= stage_d;
			level_q <= level_d;
		end
	end

endmodule

// [msp_top.sv]
// Power-mode sequencer of the motion sensor: tracking, nap, sleep,
// hibernate, wake and reset wait, plus the tracking-data read path.
// Assumes an SPI engine outside that turns commands into one-cycle pulses
// and a front end that delivers deltas and gross-motion pulses on clk.
`timescale 1ns/1ns

module msp_top
	import msp_pkg::*;
#(
	parameter logic [31:0] RST_CYCLES   = RESET_CYC,
	parameter logic [31:0] WAKE_CYCLES  = WAKE_CYC,
	parameter logic [31:0] NAP_CYCLES   = NAP_CYC,
	parameter logic [31:0] SLEEP_CYCLES = SLEEP_CYC
)
(
	// Clock and control
	input  wire logic  clk,
	input  wire logic  sys_rst,
	input  wire logic  clk_en,
	// Pins and configuration
	input  wire logic  hibernate_request_pin,
	input  wire logic  low_power_off,
	// Motion front end
	input  wire logic  gross_motion,
	input  wire logic  delta_valid,
	input  msp_motion_t delta,
	// Commands from the SPI engine
	input  wire logic  cmd_read_track,
	input  wire logic  cmd_soft_reset,
	// Status and answers
	output logic       motion_ready_q,
	output logic       low_current_q,
	output msp_mode_t  mode_q,
	output logic       rsp_valid_q,
	output msp_motion_t rsp_data_q
);

	msp_mode_t   mode_d;
	logic [31:0] timer_q;
	logic [31:0] timer_d;
	logic        cfg_q;
	logic        cfg_d;
	logic        first_q;
	logic        first_d;
	logic        ready_d;
	logic        low_current_d;
	logic        rsp_valid_d;
	msp_motion_t rsp_data_d;
	logic        hib_level;
	logic        moving;
	logic        read_ok;
	logic        reset_ok;
	msp_motion_t acc;

	function automatic logic nonzero(input msp_motion_t m);
		return (m.x != '0) || (m.y != '0);
	endfunction

	function automatic logic at_end(input logic [31:0] t,
		input logic [31:0] n);
		return t >= n - 32'h0000_0001;
	endfunction

	// ==========================================================
	// Pin synchroniser and accumulators
	msp_sync u_hib_sync (
		.clk     (clk),
		.sys_rst (sys_rst),
		.clk_en  (clk_en),
		.pin_in  (hibernate_request_pin),
		.level_q (hib_level)
	);

	msp_accum u_accum (
		.clk     (clk),
		.sys_rst (sys_rst),
		.clk_en  (clk_en),
		.add_en  (delta_valid && mode_q == MSP_TRACK),
		.delta   (delta),
		.clear   (read_ok || mode_q == MSP_WAKE),
		.acc_q   (acc)
	);

	// Commands count only while ready is shown.
	// A read and a soft reset in one cycle: the read wins, the reset is lost.
	assign read_ok  = cmd_read_track && motion_ready_q;
	assign reset_ok = cmd_soft_reset && motion_ready_q && !read_ok;
	assign moving   = gross_motion || (delta_valid && nonzero(delta));

	// ==========================================================
	// Mode sequencer
	always_comb
	begin
		mode_d  = mode_q;
		timer_d = timer_q + 32'h0000_0001;
		first_d = first_q;
		cfg_d   = cfg_q;
		case (mode_q)
			MSP_RESET:
			begin
				if (at_end(timer_q, RST_CYCLES))
				begin
					mode_d = MSP_TRACK;
				end
			end
			MSP_TRACK:
			begin
				if (moving)
				begin
					timer_d = TIMER_RST;
				end
				else if (!cfg_q && at_end(timer_q, NAP_CYCLES))
				begin
					mode_d = MSP_NAP;
				end
			end
			MSP_NAP:
			begin
				if (moving)
				begin
					mode_d = MSP_TRACK;
				end
				else if (at_end(timer_q, SLEEP_CYCLES))
				begin
					mode_d = MSP_SLEEP;
				end
			end
			MSP_SLEEP:
			begin
				timer_d = TIMER_RST;
				if (moving)
				begin
					mode_d = MSP_TRACK;
				end
			end
			MSP_HIBER:
			begin
				timer_d = TIMER_RST;
				if (!hib_level)
				begin
					mode_d = MSP_WAKE;
				end
			end
			MSP_WAKE:
			begin
				if (at_end(timer_q, WAKE_CYCLES))
				begin
					mode_d  = MSP_TRACK;
					first_d = 1'b1;
				end
			end
			default:
			begin
				mode_d = MSP_RESET;
			end
		endcase
		if (reset_ok)
		begin
			mode_d = MSP_RESET;
		end
		// Hibernate overrides everything except the reset wait.
		if (hib_level && mode_q != MSP_RESET)
		begin
			mode_d = MSP_HIBER;
		end
		// Every mode change restarts the timer, so each wait starts from zero.
		if (mode_d != mode_q)
		begin
			timer_d = TIMER_RST;
		end
		if (read_ok)
		begin
			first_d = 1'b0;
		end
		if (mode_d == MSP_HIBER || mode_d == MSP_RESET)
		begin
			first_d = 1'b0;
		end
		ready_d       = mode_d == MSP_TRACK;
		low_current_d = mode_d == MSP_HIBER;
	end

	// ==========================================================
	// Read path
	always_comb
	begin
		rsp_valid_d = read_ok;
		rsp_data_d  = rsp_data_q;
		if (read_ok)
		begin
			rsp_data_d = first_q ? MOTION_ZERO : acc;
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			mode_q         <= MSP_RESET;
			timer_q        <= TIMER_RST;
			first_q        <= 1'b0;
			cfg_q          <= low_power_off;
			motion_ready_q <= 1'b0;
			low_current_q  <= 1'b0;
			rsp_valid_q    <= 1'b0;
			rsp_data_q     <= MOTION_ZERO;
		end
		else if (clk_en)
		begin
			mode_q         <= mode_d;
			timer_q        <= timer_d;
			first_q        <= first_d;
			cfg_q          <= cfg_d;
			motion_ready_q <= ready_d;
			low_current_q  <= low_current_d;
			rsp_valid_q    <= rsp_valid_d;
			rsp_data_q     <= rsp_data_d;
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk iff clk_en);
	endclocking
	default disable iff (sys_rst);

	ready_in_track_a: assert property (
		motion_ready_q == (mode_q == MSP_TRACK))
		else $error("motion ready does not match tracking mode");

	hib_entry_a: assert property (
		hib_level && mode_q != MSP_RESET |=> mode_q == MSP_HIBER
			&& low_current_q)
		else $error("hibernate not entered after request");

	hib_hold_a: assert property (
		mode_q == MSP_HIBER && hib_level |=> mode_q == MSP_HIBER
			&& $stable(u_accum.acc_q))
		else $error("hibernate left or sensed while requested");

	wake_bound_a: assert property (
		mode_q == MSP_WAKE |-> timer_q < WAKE_CYCLES)
		else $error("wake from hibernate too slow");

	nap_wake_a: assert property (
		mode_q == MSP_NAP && moving && !hib_level |=> motion_ready_q)
		else $error("nap did not return to tracking on motion");

	sleep_wake_a: assert property (
		mode_q == MSP_SLEEP && gross_motion && !hib_level
			|=> mode_q == MSP_TRACK)
		else $error("sleep did not return to tracking on motion");

	sleep_stay_a: assert property (
		mode_q == MSP_SLEEP && !moving && !hib_level
			|=> mode_q == MSP_SLEEP)
		else $error("sleep left without motion");

	no_low_power_a: assert property (
		cfg_q |-> mode_q != MSP_NAP && mode_q != MSP_SLEEP)
		else $error("nap or sleep with low power disabled");

	nap_entry_a: assert property (
		mode_q == MSP_TRACK && !cfg_q && !moving && !hib_level
			&& !cmd_soft_reset && timer_q == NAP_CYCLES - 32'h1
			|=> mode_q == MSP_NAP)
		else $error("nap not entered after stillness");

	motion_restart_a: assert property (
		mode_q == MSP_TRACK && moving && !hib_level && !reset_ok
			|=> timer_q == TIMER_RST)
		else $error("motion did not restart inactivity timer");

	refuse_cmd_a: assert property (
		cmd_read_track && !motion_ready_q |=> !rsp_valid_q)
		else $error("command answered while not ready");

	first_zero_a: assert property (
		read_ok && first_q |=> rsp_valid_q && rsp_data_q == MOTION_ZERO)
		else $error("first read after hibernate not zero");

	read_clear_a: assert property (
		read_ok && !delta_valid |=> u_accum.acc_q == MOTION_ZERO)
		else $error("accumulators not cleared by read");

	read_answer_a: assert property (
		read_ok |=> rsp_valid_q)
		else $error("taken read not answered");

	rsp_once_a: assert property (
		!read_ok |=> !rsp_valid_q)
		else $error("answer without a taken read");

	// The default clock skips frozen edges, so this one names every edge.
	freeze_a: assert property (@(posedge clk) disable iff (sys_rst)
		!clk_en |=> $stable(mode_q) && $stable(timer_q)
			&& $stable(u_accum.acc_q))
		else $error("state moved while the clock enable was low");

	nap_seen_c: cover property (mode_q == MSP_NAP);
	sleep_seen_c: cover property (mode_q == MSP_SLEEP);
	wake_done_c: cover property (mode_q == MSP_WAKE ##1 mode_q == MSP_TRACK);
	two_reads_c: cover property (read_ok && first_q ##[1:20] read_ok);

endmodule

// [testbench.sv]
// Self-checking bench of the power-mode sequencer with scaled timers.
// Assumes the controller model issues commands and the hibernate request.
`timescale 1ns/1ns

module testbench;
	import msp_pkg::*;
	localparam logic [31:0] RC = 32'h14;
	localparam logic [31:0] WC = 32'h0A;
	localparam logic [31:0] NC = 32'h32;
	localparam logic [31:0] SC = 32'h64;
	logic        clk;
	logic        sys_rst;
	logic        clk_en;
	logic        low_power_off;
	logic        gross_motion;
	logic        delta_valid;
	msp_motion_t delta;
	logic        hib;
	logic        rd;
	logic        sr;
	logic        mrdy;
	logic        lowc;
	msp_mode_t   mode;
	logic        rv;
	msp_motion_t rdata;
	msp_motion_t acc;
	msp_motion_t exp_q[$];
	int          n_errors;
	int          checks_done;
	int          cyc;
	int          wn;

	msp_top #(.RST_CYCLES(RC), .WAKE_CYCLES(WC), .NAP_CYCLES(NC),
		.SLEEP_CYCLES(SC)) uut (.clk(clk), .sys_rst(sys_rst),
		.clk_en(clk_en), .hibernate_request_pin(hib),
		.low_power_off(low_power_off), .gross_motion(gross_motion),
		.delta_valid(delta_valid), .delta(delta), .cmd_read_track(rd),
		.cmd_soft_reset(sr), .motion_ready_q(mrdy), .low_current_q(lowc),
		.mode_q(mode), .rsp_valid_q(rv), .rsp_data_q(rdata));

	msp_ctrl_model ctl (.clk(clk), .motion_ready_q(mrdy),
		.hibernate_request_pin(hib), .cmd_read_track(rd),
		.cmd_soft_reset(sr));

	always #5 clk = !clk;

	// ==========================================================
	// Checking and closing
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			n_errors++;
			$display("wrong value at %0t: got %h, expected %h", $time,
				got, exp);
		end
	endtask

	task automatic test_done();
		$display("errors %0d, checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Every answer must match the oldest noted expectation.
	always @(negedge clk)
	begin
		cyc++;
		if (cyc == 32'h4E20)
		begin
			n_errors++;
			test_done();
		end
		if (rv === 1'b1 && exp_q.size() == 0)
			check(32'h1, 32'h0);
		else if (rv === 1'b1)
			check(rdata, exp_q.pop_front());
	end

	// ==========================================================
	// Stimulus helpers
	task automatic do_reset(input logic lp);
		sys_rst = 1'b1;
		low_power_off = lp;
		repeat (6) @(negedge clk);
		check({mode, mrdy, lowc, rv}, {MSP_RESET, 3'h0});
		sys_rst = 1'b0;
	endtask

	task automatic wait_mode(input msp_mode_t m, input int lo, input int hi);
		int n;
		for (n = 0; n < hi && mode !== m; n++)
			@(negedge clk);
		check(mode, m);
		check(n >= lo, 1'b1);
	endtask

	task automatic move(input int n);
		repeat (n)
		begin
			@(negedge clk);
			delta_valid = 1'b1;
			delta.x = 16'($urandom_range(0, 40)) - 16'h14;
			delta.y = 16'($urandom_range(0, 40)) - 16'h14;
			acc.x += delta.x;
			acc.y += delta.y;
		end
		@(negedge clk);
		delta_valid = 1'b0;
	endtask

	task automatic freeze(input int n);
		@(negedge clk);
		clk_en = 1'b0;
		repeat (n) @(negedge clk);
		check({mode, mrdy}, {MSP_RESET, 1'b0});
		clk_en = 1'b1;
	endtask

	task automatic bump();
		@(negedge clk);
		gross_motion = 1'b1;
		@(negedge clk);
		gross_motion = 1'b0;
	endtask

	task automatic read(input bit zero);
		exp_q.push_back(zero ? MOTION_ZERO : acc);
		acc = MOTION_ZERO;
		ctl.pulse(1'b1);
	endtask

	// ==========================================================
	// Main sequence
	initial
	begin
		clk = 1'b0;
		clk_en = 1'b1;
		gross_motion = 1'b0;
		delta_valid = 1'b0;
		delta = MOTION_ZERO;
		acc = MOTION_ZERO;
		void'($urandom(32'h35431A86));
		do_reset(1'b0);
		freeze($urandom_range(20, 30));
		wait_mode(MSP_TRACK, RC - 2, RC + 3);
		check(mrdy, 1'b1);
		move(8);
		read(1'b0);
		read(1'b0);
		repeat (3)
		begin
			repeat (NC - 20) @(negedge clk);
			bump();
			check(mode, MSP_TRACK);
		end
		wait_mode(MSP_NAP, NC - 4, NC + 3);
		check({mrdy, lowc}, 2'h0);
		ctl.pulse(1'b1);
		bump();
		wait_mode(MSP_TRACK, 0, 2);
		wait_mode(MSP_NAP, NC - 4, NC + 3);
		wait_mode(MSP_SLEEP, SC - 4, SC + 3);
		repeat (3 * SC) @(negedge clk);
		check(mode, MSP_SLEEP);
		ctl.pulse(1'b0);
		bump();
		wait_mode(MSP_TRACK, 0, 2);
		move(4);
		ctl.set_hib(1'b1);
		wait_mode(MSP_HIBER, 0, 8);
		check({mrdy, lowc}, 2'h1);
		bump();
		repeat (20) @(negedge clk);
		check(mode, MSP_HIBER);
		ctl.set_hib(1'b0);
		acc = MOTION_ZERO;
		ctl.wait_ready(WC + 8, wn);
		check(wn >= WC, 1'b1);
		check(mode, MSP_TRACK);
		move(4);
		read(1'b1);
		move(3);
		read(1'b0);
		ctl.pulse(1'b0);
		wait_mode(MSP_RESET, 0, 3);
		wait_mode(MSP_TRACK, RC - 8, RC + 3);
		do_reset(1'b1);
		wait_mode(MSP_TRACK, RC - 2, RC + 3);
		repeat (NC + SC) @(negedge clk);
		check(mode, MSP_TRACK);
		repeat (4) @(negedge clk);
		check(exp_q.size(), 32'h0);
		test_done();
	end
endmodule
